// ### src/uosfr_pkg.sv
package uosfr_pkg;

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [11:0] UOSFR_OFF_CONTROL = 12'h800; // general_control_reg
  localparam logic [11:0] UOSFR_OFF_STATUS = 12'h804; // general_status_reg
  localparam logic [11:0] UOSFR_OFF_CLEAR = 12'h808; // status_flag_clear
  localparam logic [11:0] UOSFR_OFF_SET = 12'h80c; // status_flag_set
  localparam logic [11:0] UOSFR_OFF_IRQ_EN = 12'h810; // interrupt enables
  localparam logic [11:0] UOSFR_OFF_VERSION = 12'h818; // module_version
  localparam logic [11:0] UOSFR_OFF_CAPS = 12'h81c; // capability_report

  // ==========================================================================
  // Status flag bit positions (shared by clear, set and enable registers)
  // ==========================================================================
  localparam int UOSFR_FLAG_W = 10;
  localparam int UOSFR_BIT_ID_EDGE = 0;
  localparam int UOSFR_BIT_VBUS_EDGE = 1;
  localparam int UOSFR_BIT_VBUS_ERR = 3;
  localparam int UOSFR_BIT_BCONN_ERR = 4;
  localparam int UOSFR_BIT_ROLE_SWAP = 5;
  localparam int UOSFR_BIT_SUSP_TO = 7;
  localparam int UOSFR_BIT_VBUS_REQ = 9;
  // Pad levels shown in the status register
  localparam int UOSFR_BIT_ID_LEVEL = 10;
  localparam int UOSFR_BIT_VBUS_LEVEL = 11;

  // Writable flag bits and the subset that can interrupt
  localparam logic [9:0] UOSFR_FLAG_MASK = 10'h2bb;
  localparam logic [9:0] UOSFR_IRQ_MASK = 10'h0bb;

  // ==========================================================================
  // Control register bits
  // ==========================================================================
  localparam int UOSFR_CTL_MODULE_EN = 0;
  localparam int UOSFR_CTL_OTG_PAD_EN = 1;
  localparam int UOSFR_CTL_CLK_FREEZE = 2;
  localparam logic [2:0] UOSFR_CTL_RESET = 3'h0;

  // ==========================================================================
  // Capability field positions and reset values
  // ==========================================================================
  localparam int UOSFR_CAP_EP_LSB = 0;
  localparam int UOSFR_CAP_CHAN_LSB = 4;
  localparam int UOSFR_CAP_LEN24 = 7;
  localparam int UOSFR_CAP_FIFO_LSB = 8;
  localparam int UOSFR_CAP_MEM_LSB = 12;
  localparam int UOSFR_CAP_BYTEWR = 15;
  localparam int UOSFR_CAP_PATH16 = 16;
  localparam int UOSFR_CAP_HBISO_LSB = 17;
  localparam int UOSFR_VER_VARIANT_LSB = 16;
  localparam logic [9:0] UOSFR_FLAG_RESET = 10'h000;
  localparam logic [31:0] UOSFR_ZERO_WORD = 32'h0000_0000;

endpackage : uosfr_pkg

// ### src/uosfr_regs.sv
// What this block does
// (RL1) VBUS pad level change, either direction, sets the VBUS edge flag; enabled flag interrupts.
// (RL2) VBUS edge flag clears only by writing one to its clear bit.
// (RL3) VBUS edge detection and interrupt ignore the clock freeze control.
// (RL4) Any ID pin level change sets the ID edge flag; enabled flag interrupts.
// (RL5) ID edge flag clears only by writing one to its clear bit.
// (RL6) ID edge detection ignores clock freeze, pad enable and module enable.
// (RL7) Clear register: ones clear flags at bits 9,7,5,4,3,1,0; zeros do nothing.
// (RL8) Set register: ones set the same flags for test; zeros do nothing.
// (RL9) Clear and set registers always read as zero.
// (RL10) Version register gives fixed 12-bit version, reserved variant in bits 19:16.
// (RL11) Capability bits 17..23 flag high-bandwidth isochronous on endpoints 1..7.
// (RL12) Path-width bit: one for 16-bit 30 MHz path, zero for 8-bit 60 MHz.
// (RL13) Byte-write bit: one when buffer memory natively supports byte writes.
// (RL14) Memory size code 0..6 means below 256..16384 bytes; 7 means at least 16384.
// (RL15) DMA FIFO depth code gives words; code zero means sixteen.
// (RL16) DMA length bit: one for 24-bit counters, zero for 16-bit.
// (RL17) DMA channel count field gives 1..7 channels; zero reserved.
// (RL18) Endpoint count field gives implemented endpoints; code zero means sixteen.
// (RL19) Interrupt is OR of every flag except VBUS request (bit 9) with its enable, held until all cleared.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module uosfr_regs
  import uosfr_pkg::*;
#(
  parameter logic [11:0] VERSION_NUM = 12'h123, // Arbitrary value
  parameter logic [3:0] VARIANT_NUM = 4'h0, // Arbitrary value
  parameter logic [6:0] HB_ISO_EPS = 7'h00,
  parameter logic PATH_16BIT = 1'b0,
  parameter logic MEM_BYTE_WRITE = 1'b1,
  parameter logic [2:0] MEM_SIZE_CODE = 3'h4,
  parameter int DMA_FIFO_WORDS = 16,
  parameter logic DMA_LEN_24BIT = 1'b0,
  parameter logic [2:0] DMA_CHANNELS = 3'h1,
  parameter int ENDPOINTS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic vbus_pad,
  input wire logic role_id_pin,
  input wire logic vbus_error_event,
  input wire logic bconn_error_event,
  input wire logic role_swap_event,
  input wire logic suspend_timeout_event,
  output logic module_enable,
  output logic otg_pad_enable,
  output logic clock_freeze,
  output logic vbus_request,
  output logic usb_irq
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [9:0] flags;
    logic [9:0] irq_en;
    logic [2:0] ctrl;
    logic vbus_prev;
    logic id_prev;
    logic primed;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic irq;
  } uosfr_state_type;

  uosfr_state_type state_q;
  uosfr_state_type state_d;

  // Address match, used by the write strobes; the read mux compares the full address
  function automatic logic uosfr_hit(input logic [11:0] addr, input logic [11:0] off);
    uosfr_hit = (addr[11:2] == off[11:2]);
  endfunction : uosfr_hit

  // ==========================================================================
  // Constant read words
  // ==========================================================================
  logic [31:0] version_word;
  logic [31:0] caps_word;
  logic [3:0] fifo_code;
  logic [3:0] ep_code;

  // Depth of sixteen wraps to code zero
  assign fifo_code = 4'(DMA_FIFO_WORDS % 16); // [RL15]
  assign ep_code = 4'(ENDPOINTS % 16); // [RL18]

  // Variant is reserved and carries no behaviour
  assign version_word = (32'(VARIANT_NUM) << UOSFR_VER_VARIANT_LSB)
                      | 32'(VERSION_NUM); // [RL10]

  // Capability word is fixed by build parameters
  assign caps_word = (32'(HB_ISO_EPS) << UOSFR_CAP_HBISO_LSB) // [RL11]
                   | (32'(PATH_16BIT) << UOSFR_CAP_PATH16) // [RL12]
                   | (32'(MEM_BYTE_WRITE) << UOSFR_CAP_BYTEWR) // [RL13]
                   | (32'(MEM_SIZE_CODE) << UOSFR_CAP_MEM_LSB) // [RL14]
                   | (32'(fifo_code) << UOSFR_CAP_FIFO_LSB) // [RL15]
                   | (32'(DMA_LEN_24BIT) << UOSFR_CAP_LEN24) // [RL16]
                   | (32'(DMA_CHANNELS) << UOSFR_CAP_CHAN_LSB) // [RL17]
                   | (32'(ep_code) << UOSFR_CAP_EP_LSB); // [RL18]

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  logic setup;
  logic wr_access;
  logic [9:0] hw_set;
  logic [9:0] sw_set;
  logic [9:0] sw_clr;

  assign setup = psel && !penable;
  // Writes land only at the access edge that the slave answers ready
  assign wr_access = psel && penable && pwrite && state_q.ready;

  // Pad edges and event inputs; detection is deliberately not gated by
  // clock_freeze, otg_pad_enable or module_enable so a frozen or disabled
  // controller still wakes on cable activity
  always_comb begin
    hw_set = 10'h000;
    hw_set[UOSFR_BIT_VBUS_EDGE] = state_q.primed && (vbus_pad != state_q.vbus_prev); // [RL1] [RL3]
    hw_set[UOSFR_BIT_ID_EDGE] = state_q.primed && (role_id_pin != state_q.id_prev); // [RL4] [RL6]
    hw_set[UOSFR_BIT_VBUS_ERR] = vbus_error_event;
    hw_set[UOSFR_BIT_BCONN_ERR] = bconn_error_event;
    hw_set[UOSFR_BIT_ROLE_SWAP] = role_swap_event;
    hw_set[UOSFR_BIT_SUSP_TO] = suspend_timeout_event;
  end

  // Write-one strobes, restricted to implemented flag bits
  assign sw_clr = (wr_access && uosfr_hit(paddr, UOSFR_OFF_CLEAR))
                ? (pwdata[9:0] & UOSFR_FLAG_MASK) : 10'h000; // [RL7] [RL2] [RL5]
  assign sw_set = (wr_access && uosfr_hit(paddr, UOSFR_OFF_SET))
                ? (pwdata[9:0] & UOSFR_FLAG_MASK) : 10'h000; // [RL8]

  always_comb begin
    state_d = state_q;
    // Pad history; the first sample after reset only primes it
    state_d.vbus_prev = vbus_pad;
    state_d.id_prev = role_id_pin;
    state_d.primed = 1'b1;
    // Set wins over clear so an event in the clearing cycle is kept
    state_d.flags = (state_q.flags & ~sw_clr) | sw_set | hw_set; // [RL2] [RL5] [RL7] [RL8]
    if (wr_access && uosfr_hit(paddr, UOSFR_OFF_CONTROL)) begin
      state_d.ctrl = pwdata[2:0];
    end
    if (wr_access && uosfr_hit(paddr, UOSFR_OFF_IRQ_EN)) begin
      state_d.irq_en = pwdata[9:0] & UOSFR_IRQ_MASK;
    end
    // Registered from next values so the pin tracks the flags exactly
    state_d.irq = |(state_d.flags & state_d.irq_en & UOSFR_IRQ_MASK); // [RL19] [RL1] [RL4]
    // Answer one cycle after setup: pready high in the first access cycle
    state_d.ready = setup;
    state_d.slverr = 1'b0;
    state_d.rdata = UOSFR_ZERO_WORD;
    if (setup) begin
      case (paddr)
        UOSFR_OFF_CONTROL: begin
          state_d.rdata = 32'(state_q.ctrl);
        end
        UOSFR_OFF_STATUS: begin
          state_d.rdata = 32'(state_q.flags)
                        | (32'(state_q.id_prev) << UOSFR_BIT_ID_LEVEL)
                        | (32'(state_q.vbus_prev) << UOSFR_BIT_VBUS_LEVEL);
        end
        UOSFR_OFF_CLEAR, UOSFR_OFF_SET: begin
          state_d.rdata = UOSFR_ZERO_WORD; // [RL9]
        end
        UOSFR_OFF_IRQ_EN: begin
          state_d.rdata = 32'(state_q.irq_en);
        end
        UOSFR_OFF_VERSION: begin
          state_d.rdata = version_word; // [RL10]
        end
        UOSFR_OFF_CAPS: begin
          state_d.rdata = caps_word; // [RL11]
        end
        default: begin
          // Unmapped word or misaligned address: error answer; a misaligned write to a mapped word still stores
          state_d.slverr = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q.flags <= UOSFR_FLAG_RESET;
      state_q.irq_en <= UOSFR_FLAG_RESET;
      state_q.ctrl <= UOSFR_CTL_RESET;
      state_q.vbus_prev <= 1'b0;
      state_q.id_prev <= 1'b0;
      state_q.primed <= 1'b0;
      state_q.rdata <= UOSFR_ZERO_WORD;
      state_q.ready <= 1'b0;
      state_q.slverr <= 1'b0;
      state_q.irq <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = state_q.rdata;
  assign pready = state_q.ready;
  assign pslverr = state_q.slverr;
  assign usb_irq = state_q.irq;
  assign vbus_request = state_q.flags[UOSFR_BIT_VBUS_REQ];
  assign module_enable = state_q.ctrl[UOSFR_CTL_MODULE_EN];
  assign otg_pad_enable = state_q.ctrl[UOSFR_CTL_OTG_PAD_EN];
  assign clock_freeze = state_q.ctrl[UOSFR_CTL_CLK_FREEZE];

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic clr_wr;
  logic set_wr;
  assign clr_wr = psel && penable && pwrite && pready
                && (paddr == UOSFR_OFF_CLEAR);
  assign set_wr = psel && penable && pwrite && pready
                && (paddr == UOSFR_OFF_SET);

  vbus_edge_sets_a: assert property ( // [RL1]
    state_q.primed && $changed(vbus_pad) |=> state_q.flags[UOSFR_BIT_VBUS_EDGE]
  ) else $error("vbus edge did not set its flag");

  vbus_edge_holds_a: assert property ( // [RL2]
    state_q.flags[UOSFR_BIT_VBUS_EDGE] && !(clr_wr && pwdata[UOSFR_BIT_VBUS_EDGE])
    |=> state_q.flags[UOSFR_BIT_VBUS_EDGE]
  ) else $error("vbus edge flag dropped without a clear write");

  frozen_vbus_edge_a: assert property ( // [RL3]
    clock_freeze && state_q.irq_en[UOSFR_BIT_VBUS_EDGE] && state_q.primed
    && $changed(vbus_pad) |=> usb_irq
  ) else $error("vbus edge lost while clock frozen");

  id_edge_sets_a: assert property ( // [RL4]
    state_q.primed && $changed(role_id_pin) |=> state_q.flags[UOSFR_BIT_ID_EDGE]
  ) else $error("id edge did not set its flag");

  id_edge_clear_a: assert property ( // [RL5]
    clr_wr && pwdata[UOSFR_BIT_ID_EDGE] && !$changed(role_id_pin)
    |=> !state_q.flags[UOSFR_BIT_ID_EDGE]
  ) else $error("id edge flag not cleared by write one");

  id_edge_disabled_a: assert property ( // [RL6]
    !module_enable && !otg_pad_enable && state_q.primed && $changed(role_id_pin)
    |=> state_q.flags[UOSFR_BIT_ID_EDGE]
  ) else $error("id edge lost while module disabled");

  clear_zero_keeps_a: assert property ( // [RL7]
    clr_wr && (pwdata[9:0] == 10'h000) && !set_wr
    |=> (state_q.flags & $past(state_q.flags)) == $past(state_q.flags)
  ) else $error("clear write of zeros changed a flag");

  set_writes_a: assert property ( // [RL8]
    set_wr |=> ((state_q.flags & $past(pwdata[9:0]) & UOSFR_FLAG_MASK)
               == ($past(pwdata[9:0]) & UOSFR_FLAG_MASK))
  ) else $error("set write did not set the flags");

  strobe_reads_zero_a: assert property ( // [RL9]
    psel && !penable && !pwrite
    && (paddr == UOSFR_OFF_CLEAR || paddr == UOSFR_OFF_SET)
    |=> pready && (prdata == UOSFR_ZERO_WORD)
  ) else $error("clear or set register read non-zero");

  irq_tracks_flags_a: assert property ( // [RL19]
    usb_irq == |(state_q.flags & state_q.irq_en & UOSFR_IRQ_MASK)
  ) else $error("interrupt does not match enabled flags");

  apb_answer_a: assert property (
    psel && !penable |=> pready ##1 !pready
  ) else $error("slave answer not one cycle after setup");

  cover_vbus_irq_c: cover property (
    $rose(state_q.flags[UOSFR_BIT_VBUS_EDGE]) ##[1:20] $fell(usb_irq)
  );
  cover_set_clear_c: cover property (set_wr ##[1:20] clr_wr);
  cover_caps_read_c: cover property (
    psel && penable && pready && !pwrite && (paddr == UOSFR_OFF_CAPS)
  );
  // ID edge seen while the controller is disabled
  cover_id_disabled_c: cover property (
    state_q.primed && $changed(role_id_pin) && !module_enable
  );
  // Error answer to an unmapped word
  cover_slverr_c: cover property (pready && pslverr);

endmodule : uosfr_regs

`default_nettype wire

// ### verification/uosfr_pad_model.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Far-side pad model: VBUS and ID levels
// ============================================================
module uosfr_pad_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flip_vbus,
  input wire logic flip_id,
  output logic vbus_pad,
  output logic role_id_pin
);
  // Levels move only just after an edge, so the block sees clean samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vbus_pad <= 1'b0;
      role_id_pin <= 1'b1; // Idle as a B-device
    end else begin
      if (flip_vbus) vbus_pad <= ~vbus_pad;
      if (flip_id) role_id_pin <= ~role_id_pin;
    end
  end
endmodule : uosfr_pad_model

`default_nettype wire

// ### verification/usb_otg_status_feature_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module usb_otg_status_feature_regs_tb;
  import uosfr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic vbus_pad, role_id_pin, flip_vbus, flip_id, usb_irq, vbus_request;
  logic module_enable, otg_pad_enable, clock_freeze;
  logic [3:0] ev;
  logic [9:0] ef;
  int n_fail, comparisons, i;
  // Capability image for the parameters chosen below
  // Left at default: byte write 1, memory code 4, FIFO depth 16 (code 0), one DMA channel
  localparam logic [31:0] CAPS_EXP = {8'h00, 7'h55, 1'b1, 1'b1, 3'h4, 4'h0, 1'b1, 3'h1, 4'h0};
  localparam logic [31:0] VER_EXP = {12'h000, 4'h0, 4'h0, 12'h5a3};

  uosfr_regs #(.VERSION_NUM(12'h5a3), .HB_ISO_EPS(7'h55), .PATH_16BIT(1'b1),
    .DMA_LEN_24BIT(1'b1), .ENDPOINTS(16)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vbus_pad(vbus_pad), .role_id_pin(role_id_pin), .vbus_error_event(ev[0]),
    .bconn_error_event(ev[1]), .role_swap_event(ev[2]), .suspend_timeout_event(ev[3]),
    .module_enable(module_enable), .otg_pad_enable(otg_pad_enable),
    .clock_freeze(clock_freeze), .vbus_request(vbus_request), .usb_irq(usb_irq));

  uosfr_pad_model u_pads (.pclk(pclk), .presetn(presetn), .flip_vbus(flip_vbus),
    .flip_id(flip_id), .vbus_pad(vbus_pad), .role_id_pin(role_id_pin));

  // ============================================================
  // Report and compare
  // ============================================================
  task stop_test;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  task chk_w(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_w

  task chk_b(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_b

  // ============================================================
  // APB master: answer taken at the edge where pready is high
  // ============================================================
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Read before the edge's own update: the value the slave presents at that edge
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      n_fail++;
      stop_test;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle cycle so the next call never re-drives psel in this time step
    @(posedge pclk);
  endtask : apb

  // Status read: flags plus both pad levels
  task st(input logic [9:0] f);
    apb(1'b0, UOSFR_OFF_STATUS, 32'h0);
    chk_w(rd, {20'h0, vbus_pad, role_id_pin, f});
  endtask : st

  // Pad flip, then one cycle for the pad and one for the flag
  task tog(input logic v, input logic d);
    flip_vbus <= v;
    flip_id <= d;
    @(posedge pclk);
    flip_vbus <= 1'b0;
    flip_id <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : tog

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    stop_test;
  end

  initial begin
    n_fail = 0;
    comparisons = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, flip_vbus, flip_id} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    ev = 4'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Identity, capabilities, write-only reads, unmapped place
    apb(1'b0, UOSFR_OFF_CLEAR, 32'h0); chk_w(rd, UOSFR_ZERO_WORD);
    apb(1'b0, UOSFR_OFF_VERSION, 32'h0); chk_w(rd, VER_EXP);
    apb(1'b1, UOSFR_OFF_CAPS, 32'hffff_ffff);
    apb(1'b0, UOSFR_OFF_CAPS, 32'h0); chk_w(rd, CAPS_EXP);
    apb(1'b0, 12'h814, 32'h0); chk_b(err, 1'b1);
    chk_w(rd, 32'h0);
    $display("test ident done");
    // VBUS edges both ways with the clock frozen
    apb(1'b1, UOSFR_OFF_CONTROL, 32'h4); chk_b(clock_freeze, 1'b1);
    apb(1'b1, UOSFR_OFF_IRQ_EN, 32'h2);
    tog(1'b1, 1'b0); st(10'h002);
    chk_b(usb_irq, 1'b1);
    apb(1'b1, UOSFR_OFF_CLEAR, 32'h3fd); st(10'h002);
    apb(1'b1, UOSFR_OFF_CLEAR, 32'h2); st(10'h000);
    chk_b(usb_irq, 1'b0);
    tog(1'b1, 1'b0); st(10'h002);
    apb(1'b1, UOSFR_OFF_CLEAR, 32'h2);
    $display("test vbus done");
    // ID edge with pads and module off, enable applied late
    apb(1'b1, UOSFR_OFF_IRQ_EN, 32'h0);
    tog(1'b0, 1'b1); st(10'h001);
    chk_b(usb_irq, 1'b0);
    apb(1'b1, UOSFR_OFF_IRQ_EN, 32'h1); chk_b(usb_irq, 1'b1);
    tog(1'b0, 1'b1);
    apb(1'b1, UOSFR_OFF_CLEAR, 32'h2); st(10'h001);
    apb(1'b1, UOSFR_OFF_CLEAR, 32'h1); st(10'h000);
    $display("test id done");
    // Set all, then clear one flag at a time
    apb(1'b1, UOSFR_OFF_SET, 32'hffff_ffff); st(10'h2bb);
    chk_b(vbus_request, 1'b1);
    apb(1'b0, UOSFR_OFF_SET, 32'h0); chk_w(rd, UOSFR_ZERO_WORD);
    apb(1'b1, UOSFR_OFF_SET, 32'h0); st(10'h2bb);
    apb(1'b1, UOSFR_OFF_CLEAR, 32'h0); st(10'h2bb);
    ef = 10'h2bb;
    for (i = 0; i < 10; i++) begin
      if (UOSFR_FLAG_MASK[i]) begin
        ef[i] = 1'b0;
        apb(1'b1, UOSFR_OFF_CLEAR, 32'h1 << i); st(ef);
      end
    end
    chk_b(vbus_request, 1'b0);
    $display("test set clear done");
    // Interrupt is the OR of enabled flags
    apb(1'b1, UOSFR_OFF_IRQ_EN, 32'h3ff);
    ev <= 4'hf;
    @(posedge pclk);
    ev <= 4'h0;
    @(posedge pclk);
    st(10'h0b8); chk_b(usb_irq, 1'b1);
    apb(1'b1, UOSFR_OFF_CLEAR, 32'h8); chk_b(usb_irq, 1'b1);
    apb(1'b1, UOSFR_OFF_CLEAR, 32'hb0); chk_b(usb_irq, 1'b0);
    apb(1'b1, UOSFR_OFF_SET, 32'h200); chk_b(usb_irq, 1'b0);
    $display("test irq done");
    stop_test;
  end
endmodule : usb_otg_status_feature_regs_tb

`default_nettype wire
